// >>> common/smbus_target_consts.vh
// Purpose: constants for the smbus target register access block
// Assumes: 10 MHz system clock
// Notes:   addresses are 7-bit, the r/w bit is appended on the wire
`ifndef SMBUS_TARGET_CONSTS_VH
`define SMBUS_TARGET_CONSTS_VH

`define ADDR_SEL_LOW      7'h2c
`define ADDR_SEL_HIGH     7'h2d
`define ADDR_NO_SELECT    7'h2e
`define ALERT_RESP_ADDR   7'h0c
`define CLK_FREQ_HZ       10000000
`define BUS_TIMEOUT_MS    35
`define BUS_TIMEOUT_CYC   ((`CLK_FREQ_HZ / 1000) * `BUS_TIMEOUT_MS)
`define PTR_RESET         8'h00
`define BYTE_BITS         4'h8
`define FIFO_DEPTH        8

`endif

// >>> logic/byte_fifo.v
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clock,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0]      wr_r;
  reg [AW:0]      rd_r;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;
  wire [AW-1:0]   head_idx;

  // extra pointer bit tells full from empty
  assign full      = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty     = (wr_r == rd_r);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;
  // slot that is the head after this edge
  assign head_idx  = pop ? rd_r[AW-1:0] + 1'b1 : rd_r[AW-1:0];

  // storage write
  always @(posedge clock) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

  // pointers and registered head word
  always @(posedge clock) begin
    if (rst) begin
      wr_r     <= {(AW+1){1'b0}};
      rd_r     <= {(AW+1){1'b0}};
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      // a word written into the new head slot bypasses the array, which still holds old data
      if (push && wr_r[AW-1:0] == head_idx) begin
        out_data <= in_data;
      end else begin
        out_data <= mem_r[head_idx];
      end
    end
  end
endmodule // byte_fifo

// >>> logic/smbus_target.v
// Purpose: smbus target giving a host access to an internal register file
// Assumes: 10 MHz clock, scl/sda pins sampled through two flip-flops
// Notes:   register writes leave through a fifo; read data comes from a port
//
// Functional notes
// - straps pick address 0x2c, 0x2d or 0x2e
// - each byte is eight bits plus ack
// - sda rising during scl high is stop
// - direction fixed at start of each operation
// - one or two write bytes, one read byte
// - first write byte loads the register pointer
// - second write byte stores to pointed register
// - read without pointer write uses current pointer
// - send byte only sets the pointer
// - write byte writes data to register
// - receive byte returns pointed register contents
// - repeated start accepted instead of stop
// - read byte: pointer write then repeated start
// - alert output is active-low open drain
// - alerting target answers alert response address
// - lowest address wins, losers release sda
// - alert released only when cause is gone
// - address fixed at eighth rising edge of match
// - 35 ms bus idle releases bus unless disabled
`timescale 1ns/1ps
`include "smbus_target_consts.vh"
module smbus_target #(
  parameter TIMEOUT_CYC = `BUS_TIMEOUT_CYC,
  parameter FIFO_DEPTH  = `FIFO_DEPTH
) (
  input  wire       clock,
  input  wire       rst,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  output wire       alert_n_out,
  output wire       alert_n_oe,
  input  wire       address_enable_strap,
  input  wire       address_select_strap,
  input  wire       bus_timeout_disable,
  input  wire       alert_cause,
  output reg  [7:0] reg_ptr,
  input  wire [7:0] reg_rdata,
  output wire [15:0] wr_data,
  output wire       wr_valid,
  input  wire       wr_ready
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_AACK  = 3'h2;
  localparam ST_WBYTE = 3'h3;
  localparam ST_WACK  = 3'h4;
  localparam ST_RBYTE = 3'h5;
  localparam ST_RACK  = 3'h6;
  localparam ST_SKIP  = 3'h7;

  reg  [1:0]  scl_s_r;
  reg  [1:0]  sda_s_r;
  reg  [1:0]  en_s_r;
  reg  [1:0]  sel_s_r;
  reg         scl_d_r;
  reg         sda_d_r;
  reg  [2:0]  state_r;
  reg  [3:0]  bit_r;
  reg  [7:0]  shift_r;
  reg  [1:0]  wcnt_r;
  reg         drive_low_r;
  reg         lost_r;
  reg         ara_r;
  reg  [6:0]  addr_r;
  reg         addr_locked_r;
  reg         alert_r;
  reg  [31:0] idle_cnt_r;
  reg         fifo_push_r;
  reg  [15:0] fifo_word_r;
  wire        scl;
  wire        sda;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_ev;
  wire        stop_ev;
  wire [6:0]  strap_addr;
  wire [6:0]  my_addr;
  wire        fifo_in_ready;
  wire        timeout;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  always @(posedge clock) begin
    if (rst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  assign scl      = scl_s_r[1];
  assign sda      = sda_s_r[1];
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  // sda moving while scl high marks start or stop, never data
  assign start_ev = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_ev  = scl & scl_d_r & ~sda_d_r & sda;

  ////////////////////////////////////////////////////////////////////////////
  // address straps; once locked they are no longer looked at
  // straps are pins too: two flops before the address decode reads them
  always @(posedge clock) begin
    en_s_r  <= {en_s_r[0], address_enable_strap};
    sel_s_r <= {sel_s_r[0], address_select_strap};
  end

  assign strap_addr = en_s_r[1] ? `ADDR_NO_SELECT :
                      (sel_s_r[1] ? `ADDR_SEL_HIGH : `ADDR_SEL_LOW);
  assign my_addr    = addr_locked_r ? addr_r : strap_addr;

  always @(posedge clock) begin
    if (rst) begin
      addr_r        <= `ADDR_SEL_LOW;
      addr_locked_r <= 1'b0;
    end else if (state_r == ST_ADDR && scl_rise && bit_r == 4'h7 && !addr_locked_r &&
                 shift_r[6:0] == strap_addr) begin
      // eighth rising edge: seven address bits are in the shifter
      addr_r        <= strap_addr;
      addr_locked_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert line follows its cause; cleared only when the cause has gone
  always @(posedge clock) begin
    if (rst) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= alert_cause;
    end
  end

  assign alert_n_out = 1'b0;
  assign alert_n_oe  = alert_r;

  ////////////////////////////////////////////////////////////////////////////
  // idle timeout; counts while a transfer is open and nothing moves
  assign timeout = !bus_timeout_disable && (idle_cnt_r >= TIMEOUT_CYC - 1);

  always @(posedge clock) begin
    if (rst || state_r == ST_IDLE || scl_rise || scl_fall) begin
      idle_cnt_r <= 32'h0;
    end else if (!timeout) begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write stream: pointer and data leave as one word per second (data) write byte
  always @(posedge clock) begin
    if (rst) begin
      fifo_push_r <= 1'b0;
      fifo_word_r <= 16'h0;
    end else if (fifo_push_r && !fifo_in_ready) begin
      fifo_push_r <= 1'b1;                            // hold until accepted
    end else begin
      fifo_push_r <= 1'b0;
      // a full fifo nacks the byte, so it must not be queued later either
      if (state_r == ST_WBYTE && scl_fall && bit_r == `BYTE_BITS && wcnt_r == 2'h1 &&
          fifo_in_ready) begin
        fifo_push_r <= 1'b1;
        fifo_word_r <= {reg_ptr, shift_r};
      end
    end
  end

  byte_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_data   (fifo_word_r),
    .in_valid  (fifo_push_r),
    .in_ready  (fifo_in_ready),
    .out_data  (wr_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // main bit engine; bit_r counts scl rises within a byte
  always @(posedge clock) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      bit_r       <= 4'h0;
      shift_r     <= 8'h0;
      wcnt_r      <= 2'h0;
      drive_low_r <= 1'b0;
      lost_r      <= 1'b0;
      ara_r       <= 1'b0;
      reg_ptr     <= `PTR_RESET;
    end else if (start_ev) begin
      // repeated start is just another start; direction is chosen anew
      state_r     <= ST_ADDR;
      bit_r       <= 4'h0;
      wcnt_r      <= 2'h0;
      drive_low_r <= 1'b0;
      lost_r      <= 1'b0;
      ara_r       <= 1'b0;
    end else if (stop_ev || timeout) begin
      state_r     <= ST_IDLE;
      drive_low_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda};
            bit_r   <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == `BYTE_BITS) begin
            bit_r <= 4'h0;
            if (shift_r[7:1] == my_addr) begin
              state_r     <= ST_AACK;
              drive_low_r <= 1'b1;
            end else if (shift_r[7:1] == `ALERT_RESP_ADDR && shift_r[0] && alert_r) begin
              state_r     <= ST_AACK;
              ara_r       <= 1'b1;
              drive_low_r <= 1'b1;
            end else begin
              state_r <= ST_SKIP;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_r <= 4'h0;
            if (shift_r[0]) begin
              state_r <= ST_RBYTE;
              // answer is own address with r/w low, or the pointed register
              shift_r     <= ara_r ? {my_addr, 1'b0} : reg_rdata;
              drive_low_r <= ara_r ? ~my_addr[6] : ~reg_rdata[7];
            end else begin
              state_r     <= ST_WBYTE;
              drive_low_r <= 1'b0;
            end
          end
        end
        ST_WBYTE: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda};
            bit_r   <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == `BYTE_BITS) begin
            bit_r <= 4'h0;
            if (wcnt_r == 2'h0) begin
              reg_ptr     <= shift_r;
              wcnt_r      <= 2'h1;
              state_r     <= ST_WACK;
              drive_low_r <= 1'b1;
            end else if (wcnt_r == 2'h1) begin
              wcnt_r      <= 2'h2;
              state_r     <= ST_WACK;
              drive_low_r <= fifo_in_ready;           // full stream refuses the byte
            end else begin
              state_r <= ST_SKIP;                     // third byte gets no ack
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_r     <= ST_WBYTE;
            drive_low_r <= 1'b0;
          end
        end
        ST_RBYTE: begin
          if (scl_rise) begin
            // arbitration: released high but line low means we lost
            if (!drive_low_r && !sda) begin
              lost_r <= 1'b1;
            end
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall) begin
            if (bit_r == `BYTE_BITS || lost_r) begin
              state_r     <= (bit_r == `BYTE_BITS) ? ST_RACK : ST_SKIP;
              drive_low_r <= 1'b0;
            end else begin
              shift_r     <= {shift_r[6:0], 1'b0};
              drive_low_r <= ~shift_r[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            // only one byte per read, whatever the host answers
            state_r <= ST_SKIP;
          end
        end
        ST_SKIP: begin
          drive_low_r <= 1'b0;
        end
        default: begin
          state_r     <= ST_IDLE;
          drive_low_r <= 1'b0;
        end
      endcase
    end
  end

  // open drain: we only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_r & ~lost_r;
endmodule // smbus_target

// >>> verif/smbus_target_assertions.sv
// Purpose: pin-level properties of the smbus target
// Assumes: one clock domain, rst synchronous active high
// Notes:   bound to every smbus_target instance
`timescale 1ns/1ps
module smbus_target_assertions #(
  parameter TIMEOUT_CYC = 2000,
  parameter FIFO_DEPTH  = 8
) (
  input wire        clock,
  input wire        rst,
  input wire        scl_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        alert_n_out,
  input wire        alert_n_oe,
  input wire        bus_timeout_disable,
  input wire        alert_cause,
  input wire [7:0]  reg_ptr,
  input wire [15:0] wr_data,
  input wire        wr_valid,
  input wire        wr_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // cycles sda is held low; a stuck transfer must let go by the idle timeout
  integer low_r;
  always @(posedge clock) low_r <= (rst || !sda_oe || bus_timeout_disable) ? 0 : low_r + 1;
  ////////////////////////////////////////
  a_pins_open_drain: assert property (!sda_out && !alert_n_out)
    else $error("open drain pin value not low");
  a_alert_tracks: assert property (!$past(rst) |-> alert_n_oe == $past(alert_cause))
    else $error("alert drive not following its cause");
  a_alert_release: assert property ($fell(alert_n_oe) |-> !$past(alert_cause))
    else $error("alert released while cause present");
  a_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda drive began outside scl low");
  a_ptr_scl_low: assert property ($changed(reg_ptr) |-> !scl_in)
    else $error("pointer moved while scl high");
  a_push_scl_low: assert property ($rose(wr_valid) |-> !scl_in)
    else $error("write word pushed while scl high");
  a_head_holds: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write word lost before accepted");
  a_timeout_bound: assert property (low_r < TIMEOUT_CYC + 8)
    else $error("sda held past idle timeout");
endmodule // smbus_target_assertions
bind smbus_target smbus_target_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC), .FIFO_DEPTH(FIFO_DEPTH))
  smbus_target_assertions_i (.clock, .rst, .scl_in, .sda_out, .sda_oe, .alert_n_out, .alert_n_oe,
  .bus_timeout_disable, .alert_cause, .reg_ptr, .wr_data, .wr_valid, .wr_ready);

// >>> verif/smbus_host_model.sv
// Purpose: smbus host model for the target bench
// Assumes: sda open drain with a pull-up
// Notes:   scl idles high between frames, 800 ns per bit
`timescale 1ns/1ps
module smbus_host (
  output logic scl,
  output logic sda_low,
  input  wire  sda
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  ////////////////////////////////////////
  // start, or repeated start after releasing sda in the low phase
  task start;
    if (!scl) begin
      #100 sda_low = 1'b0;
      #400 scl = 1'b1;
    end
    #150 sda_low = 1'b1;
    #150 scl = 1'b0;
  endtask
  // one bit: sda moves only while scl is low, sampled mid high
  task bit_io(input logic b, output logic r);
    #100 sda_low = !b;
    #400 scl = 1'b1;
    #150 r = sda;
    #150 scl = 1'b0;
  endtask
  // eight bits msb first; all ones leaves sda to the target
  task byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
  endtask
  // stop: sda low in the low phase, then rising while scl is high
  task stop;
    #100 sda_low = 1'b1;
    #400 scl = 1'b1;
    #150 sda_low = 1'b0;
    #300;
  endtask
endmodule // smbus_host

// >>> verif/smbus_target_test.sv
// Purpose: self-checking bench for the smbus target
// Assumes: host model owns scl; sda is wired-and with a pull-up
// Notes:   idle timeout shortened to 2000 cycles
`timescale 1ns/1ps
module smbus_target_test;
  localparam TO = 2000;
  localparam logic [6:0] A = 7'h2e;
  logic clock = 1'b0, rst = 1'b1, en_s = 1'b0, sel_s = 1'b0, timeout_off = 1'b0;
  logic cause = 1'b0, wr_ready = 1'b0, k;
  logic [7:0] d, rdata;
  integer error_cnt = 0, check_count = 0;
  wire sda, sda_oe, scl, host_low, wr_valid, sda_out, alert_n_out, alert_n_oe;
  wire [7:0] ptr;
  wire [15:0] wr_data;
  // released line reads high; register contents are a fixed function of the pointer
  assign sda = !(host_low || sda_oe);
  assign rdata = ptr ^ 8'h96;
  always #50 clock = ~clock;
  smbus_target #(.TIMEOUT_CYC(TO)) smbus_target_i (.clock(clock), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe), .address_enable_strap(en_s), .address_select_strap(sel_s),
    .bus_timeout_disable(timeout_off), .alert_cause(cause), .reg_ptr(ptr), .reg_rdata(rdata),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready));
  smbus_host smbus_host_i (.scl(scl), .sda_low(host_low), .sda(sda));
  ////////////////////////////////////////
  task cmp(input logic [15:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task conclude;
    $display("mismatches %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task reset_dut(input logic en, sel);
    @(negedge clock);
    rst = 1'b1;
    en_s = en;
    sel_s = sel;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // k is high when the target acknowledged
  task addr(input logic [6:0] a, input logic rd);
    smbus_host_i.start;
    smbus_host_i.byte_io({a, rd}, d);
    smbus_host_i.bit_io(1'b1, k);
    k = !k;
  endtask
  task wbyte(input logic [7:0] b);
    smbus_host_i.byte_io(b, d);
    smbus_host_i.bit_io(1'b1, k);
    k = !k;
  endtask
  // host nacks the byte and stops
  task rbyte;
    smbus_host_i.byte_io(8'hff, d);
    smbus_host_i.bit_io(1'b1, k);
    smbus_host_i.stop;
  endtask
  ////////////////////////////////////////
  // each strap setting answers one address, kept after a strap change
  task strap_addr;
    logic [6:0] own;
    for (logic [1:0] s = 2'h0; s < 2'h3; s++) begin
      reset_dut(s == 2'h2, s == 2'h1);
      own = 7'h2c + {5'h00, s};
      for (logic [7:0] a = 8'h2b; a < 8'h2f; a++) begin
        addr(a[6:0], 1'b0);
        smbus_host_i.stop;
        cmp(k, a[6:0] == own, "address answer");
      end
      @(negedge clock) en_s = !en_s;
      addr(own, 1'b0);
      smbus_host_i.stop;
      cmp(k, 1'b1, "locked address lost");
    end
  endtask
  task write_read;
    addr(A, 1'b0);
    wbyte(8'h5a);
    cmp(ptr, 8'h5a, "pointer load");
    wbyte(8'ha5);
    cmp(k, 1'b1, "data byte ack");
    wbyte(8'h11);
    cmp(k, 1'b0, "third byte acked");
    smbus_host_i.stop;
    cmp(wr_data, 16'h5aa5, "write word");
    addr(A, 1'b0);
    wbyte(8'h33);
    addr(A, 1'b1);
    rbyte;
    cmp(d, 8'h33 ^ 8'h96, "read byte data");
    addr(A, 1'b1);
    rbyte;
    cmp(d, 8'h33 ^ 8'h96, "receive byte data");
  endtask
  // fifo holds one word already; the eighth more is refused, then drain back to back
  task fifo_fill;
    for (logic [7:0] i = 8'h01; i < 8'h09; i++) begin
      addr(A, 1'b0);
      wbyte(i);
      wbyte(8'hc0 | i);
      smbus_host_i.stop;
      cmp(k, i < 8'h08, "full fifo answer");
    end
    @(negedge clock) wr_ready = 1'b1;
    for (logic [7:0] j = 8'h00; j < 8'h08; j++) begin
      cmp(wr_data, j == 8'h00 ? 16'h5aa5 : {j, 8'hc0 | j}, "fifo order");
      @(negedge clock);
    end
    wr_ready = 1'b0;
    cmp(wr_valid, 1'b0, "fifo not empty");
  endtask
  task alert_ara;
    addr(7'h0c, 1'b1);
    smbus_host_i.stop;
    cmp(k, 1'b0, "alert address acked idle");
    @(negedge clock) cause = 1'b1;
    repeat (2) @(negedge clock);
    cmp(alert_n_oe, 1'b1, "alert not driven");
    cmp({sda_out, alert_n_out}, 16'h0, "open drain value not low");
    addr(7'h0c, 1'b1);
    cmp(k, 1'b1, "alert address ack");
    rbyte;
    cmp(d, {A, 1'b0}, "alert answer");
    addr(7'h0c, 1'b1);
    smbus_host_i.byte_io(8'h56, d); // lower address competes
    smbus_host_i.bit_io(1'b1, k);
    smbus_host_i.stop;
    cmp(d, 8'h56, "lost arbitration still driving");
    @(negedge clock) cause = 1'b0;
    repeat (2) @(negedge clock);
    cmp(alert_n_oe, 1'b0, "alert not released");
  endtask
  // host stalls inside the address ack
  task idle_timeout;
    integer n;
    @(negedge clock) timeout_off = 1'b1;
    smbus_host_i.start;
    smbus_host_i.byte_io({A, 1'b0}, d);
    repeat (TO + 100) @(negedge clock);
    cmp(sda_oe, 1'b1, "released with timeout off");
    timeout_off = 1'b0;
    for (n = 0; n < TO + 100 && sda_oe !== 1'b0; n++) @(negedge clock);
    cmp(sda_oe, 1'b0, "no release after idle");
    if (sda_oe !== 1'b0) conclude;
    smbus_host_i.bit_io(1'b1, k);
    smbus_host_i.stop;
  endtask
  initial begin
    strap_addr;
    write_read;
    fifo_fill;
    alert_ara;
    idle_timeout;
    conclude;
  end
endmodule // smbus_target_test
